/* File: src/ddrsp_pkg.sv */
////////////////////////////////////////////////////////////////////////////////
// Shared constants and types for the double-data-rate SRAM data port.
////////////////////////////////////////////////////////////////////////////////
package ddrsp_pkg;

    // Period of the core reference clock in picoseconds.
    localparam int unsigned REF_PERIOD_PS = 5000;

    // Time the delay loop needs to lock, in microseconds.
    localparam int unsigned LOCK_TIME_US = 20;
    // Least lock time rounds up to whole reference cycles.
    localparam int unsigned LOCK_CYC = (LOCK_TIME_US * 1000000 + REF_PERIOD_PS - 1) /
        REF_PERIOD_PS;

    // Time without input clock activity that resets the delay loop, in nanoseconds.
    localparam int unsigned K_STATIC_NS = 30;
    // Least static time rounds up to whole reference cycles.
    localparam int unsigned K_STATIC_CYC = (K_STATIC_NS * 1000 + REF_PERIOD_PS - 1) /
        REF_PERIOD_PS;

    // Read latency of each mode in half clock cycles.
    localparam int unsigned RL20_HALVES = 4;
    localparam int unsigned RL25_HALVES = 5;
    localparam int unsigned BYPASS_HALVES = 2;

    // Depth of the read command pipeline, enough for the longest latency.
    localparam int unsigned PIPE_STAGES = 3;

    // Pin levels that mark a command.
    localparam logic STROBE_ON = 1'b0;
    localparam logic SEL_READ = 1'b1;
    localparam logic LANE_WRITE = 1'b0;

    // Read latency modes.
    typedef enum logic [1:0] {LAT_BYPASS, LAT_RL20, LAT_RL25} ddrsp_lat_t;

    // Delay loop states.
    typedef enum logic [1:0] {DLL_RESET, DLL_LOCKING, DLL_LOCKED} ddrsp_dll_t;

    // Latency in half cycles of a mode.
    function automatic int unsigned lat_halves(input ddrsp_lat_t mode);
        case (mode)
            LAT_BYPASS: lat_halves = BYPASS_HALVES;
            LAT_RL20: lat_halves = RL20_HALVES;
            default: lat_halves = RL25_HALVES;
        endcase
    endfunction : lat_halves

endpackage : ddrsp_pkg

/* File: src/ddrsp_sync.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Two-flop level synchroniser; only the second flop is visible outside.
////////////////////////////////////////////////////////////////////////////////
module ddrsp_sync #(
    parameter int unsigned W = 1
)(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] dout_q;
    logic [W-1:0] dout_d;

    // Next values: clear under reset, otherwise shift one stage.
    always_comb begin
        meta_d = rst_n ? din : '0;
        dout_d = rst_n ? meta_q : '0;
    end

    // Register both stages.
    always_ff @(posedge clk) begin
        meta_q <= meta_d;
        dout_q <= dout_d;
    end

    assign dout = dout_q;

endmodule : ddrsp_sync

/* File: src/ddrsp_dll_timer.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Delay loop lock timer and input clock watchdog, on the reference clock.
////////////////////////////////////////////////////////////////////////////////
module ddrsp_dll_timer #(
    parameter int unsigned LOCK_CYCLES = ddrsp_pkg::LOCK_CYC,
    parameter int unsigned STATIC_CYCLES = ddrsp_pkg::K_STATIC_CYC
)(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic k_toggle_s,
    output logic locked
);
    import ddrsp_pkg::*;

    localparam int unsigned CW = $clog2(LOCK_CYCLES + 1);
    localparam int unsigned SW = $clog2(STATIC_CYCLES + 1);

    ddrsp_dll_t state_q, state_d;
    logic [CW-1:0] lock_cnt_q, lock_cnt_d;
    logic [SW-1:0] idle_cnt_q, idle_cnt_d;
    logic tog_last_q, tog_last_d;
    logic locked_q, locked_d;
    logic k_edge;
    logic k_static;

    // A change of the synchronised toggle shows that the input clock ran.
    assign k_edge = k_toggle_s ^ tog_last_q;
    assign k_static = (idle_cnt_q >= SW'(STATIC_CYCLES));

    // Next state of the lock sequence.
    always_comb begin
        state_d = state_q;
        lock_cnt_d = lock_cnt_q;
        tog_last_d = k_toggle_s;
        idle_cnt_d = k_edge ? '0 : (k_static ? idle_cnt_q : idle_cnt_q + SW'(1));
        case (state_q)
            DLL_RESET: begin
                lock_cnt_d = '0;
                if (k_edge) begin
                    state_d = DLL_LOCKING;
                end
            end
            DLL_LOCKING: begin
                if (k_static) begin
                    state_d = DLL_RESET;
                end else if (lock_cnt_q == CW'(LOCK_CYCLES - 1)) begin
                    state_d = DLL_LOCKED;
                end else begin
                    lock_cnt_d = lock_cnt_q + CW'(1);
                end
            end
            DLL_LOCKED: begin
                if (k_static) begin
                    state_d = DLL_RESET;
                end
            end
            default: state_d = DLL_RESET;
        endcase
        locked_d = (state_d == DLL_LOCKED);
        if (!nrst) begin
            state_d = DLL_RESET;
            lock_cnt_d = '0;
            idle_cnt_d = '0;
            tog_last_d = 1'b0;
            locked_d = 1'b0;
        end
    end

    // Register the lock sequence.
    always_ff @(posedge ref_clk) begin
        state_q <= state_d;
        lock_cnt_q <= lock_cnt_d;
        idle_cnt_q <= idle_cnt_d;
        tog_last_q <= tog_last_d;
        locked_q <= locked_d;
    end

    assign locked = locked_q;

endmodule : ddrsp_dll_timer

/* File: src/ddrsp_port.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////
module ddrsp_port #(
    parameter int unsigned ADDR_W = 8,
    parameter int unsigned BYTE_W = 9,
    parameter int unsigned LANES = 2,
    parameter bit RL_2P5 = 1'b1,
    parameter int unsigned LOCK_CYCLES = ddrsp_pkg::LOCK_CYC,
    parameter int unsigned STATIC_CYCLES = ddrsp_pkg::K_STATIC_CYC
)(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic k_clk,
    input wire logic load_strobe_n,
    input wire logic rw_select,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [LANES*BYTE_W-1:0] d_in,
    input wire logic [LANES-1:0] byte_write_select_n,
    input wire logic dll_disable_n,
    input wire logic on_die_termination_control,
    output logic [LANES*BYTE_W-1:0] dq_out,
    output logic dq_oe_n,
    output logic echo_clock_true,
    output logic echo_clock_comp,
    output logic read_data_valid_flag,
    output logic odt_enable,
    output logic dll_locked
);
    import ddrsp_pkg::*;

    localparam int unsigned DW = LANES * BYTE_W;
    localparam int unsigned DEPTH = 1 << ADDR_W;

    // Refuse shapes the burst and lane logic cannot serve.
    generate
        if (ADDR_W < 2 || ADDR_W > 20 || LANES < 1 || BYTE_W < 1 || LOCK_CYCLES < 1 ||
            STATIC_CYCLES < 1) begin : g_bad_params
            $error("ddrsp_port: unsupported parameter values");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Helper functions.
    ////////////////////////////////////////////////////////////////////////////

    // Merge new write data into a stored word, lane by lane.
    function automatic logic [DW-1:0] lane_merge(input logic [DW-1:0] old_w,
                                                 input logic [DW-1:0] new_w,
                                                 input logic [LANES-1:0] sel_n);
        logic [DW-1:0] res;
        res = old_w;
        for (int i = 0; i < LANES; i++) begin
            if (sel_n[i] == LANE_WRITE) begin
                res[i*BYTE_W +: BYTE_W] = new_w[i*BYTE_W +: BYTE_W];
            end
        end
        return res;
    endfunction : lane_merge

    // Address of a given word within a two-word burst.
    function automatic logic [ADDR_W-1:0] burst_addr(input logic [ADDR_W-1:0] base,
                                                     input logic word);
        return base ^ {{(ADDR_W-1){1'b0}}, word};
    endfunction : burst_addr

    ////////////////////////////////////////////////////////////////////////////
    // Reference clock side: delay loop lock and clock watchdog.
    ////////////////////////////////////////////////////////////////////////////

    logic k_tog_q, k_tog_d;
    logic k_tog_s;

    // Bring the input clock activity toggle into the reference domain.
    ddrsp_sync #(.W(1)) u_ktog_sync (
        .clk(ref_clk),
        .rst_n(nrst),
        .din(k_tog_q),
        .dout(k_tog_s)
    );

    ddrsp_dll_timer #(
        .LOCK_CYCLES(LOCK_CYCLES),
        .STATIC_CYCLES(STATIC_CYCLES)
    ) u_dll_timer (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .k_toggle_s(k_tog_s),
        .locked(dll_locked)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Crossings into the link clock domain.
    ////////////////////////////////////////////////////////////////////////////

    logic link_rst_n;
    logic locked_s;
    logic dll_on_s;
    logic odt_pin_s;

    // Reset release for the link side, carried as a level.
    ddrsp_sync #(.W(1)) u_rst_sync (
        .clk(k_clk),
        .rst_n(1'b1),
        .din(nrst),
        .dout(link_rst_n)
    );

    // Lock status and the two static control pins.
    ddrsp_sync #(.W(3)) u_lvl_sync (
        .clk(k_clk),
        .rst_n(link_rst_n),
        .din({dll_locked, dll_disable_n, on_die_termination_control}),
        .dout({locked_s, dll_on_s, odt_pin_s})
    );

    ////////////////////////////////////////////////////////////////////////////
    // Link side, true clock rising edge: commands, writes, read slot of the high half.
    ////////////////////////////////////////////////////////////////////////////

    logic [DW-1:0] mem [DEPTH];
    ddrsp_lat_t lat_mode;
    int unsigned lat;
    int unsigned pos_st;
    int unsigned neg_st;
    logic pos_word;
    logic cmd_ok;
    logic rd_cmd;
    logic wr_cmd;

    logic [PIPE_STAGES-1:0] rd_v_q, rd_v_d;
    logic [ADDR_W-1:0] rd_a_q [PIPE_STAGES];
    logic [ADDR_W-1:0] rd_a_d [PIPE_STAGES];
    logic wr_pend_q, wr_pend_d;
    logic wr_commit_q, wr_commit_d;
    logic [ADDR_W-1:0] wr_a_q, wr_a_d;
    logic [ADDR_W-1:0] wc_a_q, wc_a_d;
    logic [DW-1:0] wd0_q, wd0_d;
    logic [LANES-1:0] wb0_q, wb0_d;
    logic [DW-1:0] wd1_q;
    logic [LANES-1:0] wb1_q;
    logic [DW-1:0] dq_pos_q, dq_pos_d;
    logic vld_pos_q, vld_pos_d;
    logic odt_en_q, odt_en_d;
    logic ph_pos_q;

    // Latency mode and the pipeline stages that feed each output slot.
    always_comb begin
        if (dll_on_s == 1'b0) begin
            lat_mode = LAT_BYPASS;
        end else if (RL_2P5) begin
            lat_mode = LAT_RL25;
        end else begin
            lat_mode = LAT_RL20;
        end
        lat = lat_halves(lat_mode);
        pos_st = (lat + 1) / 2 - 1;
        neg_st = lat / 2;
        pos_word = lat[0];
    end

    // Commands count once the loop is locked, or at once when it is bypassed.
    // commands ignored while locking
    assign cmd_ok = link_rst_n && ((dll_on_s == 1'b0) || locked_s);
    assign rd_cmd = cmd_ok && (load_strobe_n == STROBE_ON) && (rw_select == SEL_READ);
    assign wr_cmd = cmd_ok && (load_strobe_n == STROBE_ON) && (rw_select != SEL_READ);

    // Next values of the rising-edge state.
    always_comb begin
        rd_v_d = {rd_v_q[PIPE_STAGES-2:0], rd_cmd};
        rd_a_d[0] = addr;
        for (int i = 1; i < PIPE_STAGES; i++) begin
            rd_a_d[i] = rd_a_q[i-1];
        end
        wr_pend_d = wr_cmd;
        wr_a_d = addr;
        wr_commit_d = wr_pend_q;
        wc_a_d = wr_pend_q ? wr_a_q : wc_a_q;
        wd0_d = wr_pend_q ? d_in : wd0_q;
        wb0_d = wr_pend_q ? byte_write_select_n : wb0_q;
        vld_pos_d = rd_v_q[pos_st];
        dq_pos_d = rd_v_q[pos_st] ? mem[burst_addr(rd_a_q[pos_st], pos_word)] : '0;
        odt_en_d = odt_pin_s;
        if (!link_rst_n) begin
            rd_v_d = '0;
            wr_pend_d = 1'b0;
            wr_commit_d = 1'b0;
            vld_pos_d = 1'b0;
            dq_pos_d = '0;
            odt_en_d = 1'b0;
        end
    end

    // Register the rising-edge state.
    always_ff @(posedge k_clk) begin
        rd_v_q <= rd_v_d;
        for (int i = 0; i < PIPE_STAGES; i++) begin
            rd_a_q[i] <= rd_a_d[i];
        end
        wr_pend_q <= wr_pend_d;
        wr_a_q <= wr_a_d;
        wr_commit_q <= wr_commit_d;
        wc_a_q <= wc_a_d;
        wd0_q <= wd0_d;
        wb0_q <= wb0_d;
        dq_pos_q <= dq_pos_d;
        vld_pos_q <= vld_pos_d;
        odt_en_q <= odt_en_d;
        ph_pos_q <= link_rst_n ? ~ph_pos_q : 1'b0;
        k_tog_q <= k_tog_d;
    end

    // Activity toggle starts from a known level at link reset, then flips on every rise.
    assign k_tog_d = link_rst_n ? ~k_tog_q : 1'b0;

    // Commit both beats of a write once the second has been captured.
    always_ff @(posedge k_clk) begin
        if (wr_commit_q && link_rst_n) begin
            mem[wc_a_q] <= lane_merge(mem[wc_a_q], wd0_q, wb0_q);
            mem[burst_addr(wc_a_q, 1'b1)] <= lane_merge(mem[burst_addr(wc_a_q, 1'b1)],
                wd1_q, wb1_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link side, true clock falling edge: second beat, read slot of the low half.
    ////////////////////////////////////////////////////////////////////////////

    logic [DW-1:0] wd1_d;
    logic [LANES-1:0] wb1_d;
    logic [DW-1:0] dq_neg_q, dq_neg_d;
    logic vld_neg_q, vld_neg_d;
    logic ph_neg_q, ph_neg_d;

    // Next values of the falling-edge state.
    always_comb begin
        wd1_d = wr_commit_q ? d_in : wd1_q;
        wb1_d = wr_commit_q ? byte_write_select_n : wb1_q;
        vld_neg_d = rd_v_q[neg_st];
        dq_neg_d = rd_v_q[neg_st] ? mem[burst_addr(rd_a_q[neg_st], ~pos_word)] : '0;
        ph_neg_d = ph_pos_q;
        if (!link_rst_n) begin
            vld_neg_d = 1'b0;
            dq_neg_d = '0;
            ph_neg_d = 1'b0;
        end
    end

    // Register the falling-edge state.
    always_ff @(negedge k_clk) begin
        wd1_q <= wd1_d;
        wb1_q <= wb1_d;
        dq_neg_q <= dq_neg_d;
        vld_neg_q <= vld_neg_d;
        ph_neg_q <= ph_neg_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output pins: on data, drive enable and valid, each half cycle shows the register of its own edge.
    ////////////////////////////////////////////////////////////////////////////

    // Data, drive enable and valid flag follow the half cycle in progress.
    assign dq_out = k_clk ? dq_pos_q : dq_neg_q;
    assign dq_oe_n = ~(k_clk ? vld_pos_q : vld_neg_q);
    assign read_data_valid_flag = k_clk ? vld_pos_q : vld_neg_q;

    // Echo clocks rebuilt from the two phase flops, free of the input buffer.
    assign echo_clock_true = ph_pos_q ^ ph_neg_q;
    assign echo_clock_comp = ~(ph_pos_q ^ ph_neg_q);

    // Termination enable straight from its flop.
    assign odt_enable = odt_en_q;

endmodule : ddrsp_port

/* File: bench/ddrsp_port_assertions.sv */
`timescale 1ns/1ps
////////////////////////////////////////
// Pin timing checks for the data port.
////////////////////////////////////////
module ddrsp_port_assertions #(
    parameter bit RL_2P5 = 1'b1,
    parameter int unsigned LOCK_CYCLES = ddrsp_pkg::LOCK_CYC,
    parameter int unsigned STATIC_CYCLES = ddrsp_pkg::K_STATIC_CYC
)(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic k_clk,
    input wire logic load_strobe_n,
    input wire logic rw_select,
    input wire logic dll_disable_n,
    input wire logic on_die_termination_control,
    input wire logic dq_oe_n,
    input wire logic read_data_valid_flag,
    input wire logic odt_enable,
    input wire logic dll_locked
);
    logic tog;
    logic [2:0] tog_s;
    logic [3:0] age;
    int unsigned kstat;
    int unsigned low_cnt;
    logic rd_cmd;

    // A read command as sampled at a rise of the link clock.
    assign rd_cmd = !k_clk && load_strobe_n == 1'b0 && rw_select == 1'b1;

    // Link activity toggle and age since reset, in the link domain.
    always_ff @(posedge k_clk) begin
        if (!nrst) begin
            tog <= 1'b0;
            age <= 4'h0;
        end else begin
            tog <= ~tog;
            age <= (age == 4'hf) ? age : age + 4'h1;
        end
    end

    // Cycles without link activity and cycles spent unlocked.
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            tog_s <= 3'h0;
            kstat <= 0;
            low_cnt <= 0;
        end else begin
            tog_s <= {tog_s[1:0], tog};
            kstat <= (tog_s[2] != tog_s[1]) ? 0 : ((kstat < 255) ? kstat + 1 : kstat);
            low_cnt <= dll_locked ? 0 : low_cnt + 1;
        end
    end

    chk_bypass_lat: assert property (@(k_clk) disable iff (!nrst)
        age == 4'hf && !dll_disable_n && rd_cmd |-> ##3 !dq_oe_n ##1 !dq_oe_n ##1 dq_oe_n)
        else $error("bypass read word timing wrong");
    chk_rl25_float: assert property (@(k_clk) disable iff (!nrst)
        RL_2P5 && dll_disable_n && dll_locked && age == 4'hf && rd_cmd
        |-> ##6 !dq_oe_n ##1 !dq_oe_n ##1 dq_oe_n)
        else $error("latency 2.5 read timing wrong");
    chk_rl20_float: assert property (@(k_clk) disable iff (!nrst)
        !RL_2P5 && dll_disable_n && dll_locked && age == 4'hf && rd_cmd
        |-> ##5 !dq_oe_n ##1 !dq_oe_n ##1 dq_oe_n)
        else $error("latency 2.0 read timing wrong");
    chk_drive_cause: assert property (@(k_clk) disable iff (!nrst)
        $fell(dq_oe_n) |-> (!dll_disable_n && $past(rd_cmd, 3))
        || (dll_disable_n && RL_2P5 && $past(rd_cmd, 6))
        || (dll_disable_n && !RL_2P5 && $past(rd_cmd, 5)))
        else $error("output driven without a read at a rise");
    chk_valid_tie: assert property (@(k_clk) disable iff (!nrst)
        read_data_valid_flag == !dq_oe_n)
        else $error("valid flag and output drive disagree");
    chk_odt_off: assert property (@(posedge k_clk) disable iff (!nrst)
        !on_die_termination_control [*4] |-> !odt_enable)
        else $error("termination on while its pin is low");
    chk_lock_wait: assert property (@(posedge ref_clk) disable iff (!nrst)
        $rose(dll_locked) |-> low_cnt >= LOCK_CYCLES - 1)
        else $error("lock reported too soon");
    chk_lock_stable: assert property (@(posedge ref_clk) disable iff (!nrst)
        $rose(dll_locked) |-> kstat < 3)
        else $error("lock reported with a still clock");
    chk_static_drop: assert property (@(posedge ref_clk) disable iff (!nrst)
        kstat > STATIC_CYCLES + 6 |-> !dll_locked)
        else $error("lock kept with a still clock");
endmodule : ddrsp_port_assertions

bind ddrsp_port ddrsp_port_assertions #(.RL_2P5(RL_2P5), .LOCK_CYCLES(LOCK_CYCLES),
    .STATIC_CYCLES(STATIC_CYCLES)) u_chk (.ref_clk(ref_clk), .nrst(nrst), .k_clk(k_clk),
    .load_strobe_n(load_strobe_n), .rw_select(rw_select), .dll_disable_n(dll_disable_n),
    .on_die_termination_control(on_die_termination_control), .dq_oe_n(dq_oe_n),
    .read_data_valid_flag(read_data_valid_flag), .odt_enable(odt_enable),
    .dll_locked(dll_locked));

/* File: bench/ddrsp_ctrl_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////
// Memory controller on the far side of the port.
////////////////////////////////////////
module ddrsp_ctrl_model (
    input wire logic run,
    output logic k_clk,
    output logic load_strobe_n,
    output logic rw_select,
    output logic [7:0] addr,
    output logic [17:0] d_in,
    output logic [1:0] byte_write_select_n
);
    // Link clock of 6 ns with its own phase; it stands still while run is low.
    // clock can stop
    initial begin
        k_clk = 1'b0;
        load_strobe_n = 1'b1;
        rw_select = 1'b0;
        addr = 8'h00;
        d_in = 18'h00000;
        byte_write_select_n = 2'h3;
        #1.7;
        forever begin
            #3;
            if (run) begin
                k_clk = ~k_clk;
            end
        end
    end

    // Issues one command; returns at the rise that takes it, with beat 0 set up.
    // strobe low, select
    task automatic cmd(input logic rd, input logic [7:0] a, input logic [17:0] w0,
                       input logic [1:0] m0);
        @(posedge k_clk);
        load_strobe_n <= 1'b0;
        rw_select <= rd;
        addr <= a;
        @(posedge k_clk);
        load_strobe_n <= 1'b1;
        rw_select <= ~rd;
        addr <= ~a;
        d_in <= w0;
        byte_write_select_n <= m0;
    endtask : cmd

    // Beat 1 is set for the fall, then the data lines stop showing old values.
    task automatic beat(input logic [17:0] w1, input logic [1:0] m1);
        @(posedge k_clk);
        d_in <= w1;
        byte_write_select_n <= m1;
        @(posedge k_clk);
        d_in <= ~w1;
        byte_write_select_n <= 2'h3;
    endtask : beat
endmodule : ddrsp_ctrl_model

/* File: bench/testbench.sv */
`timescale 1ns/1ps
////////////////////////////////////////
// Self-checking bench for the data port.
////////////////////////////////////////
module testbench;
    import ddrsp_pkg::*;
    localparam int unsigned LOCK_SIM = 50;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic dll_disable_n = 1'b0;
    logic on_die_termination_control = 1'b0;
    logic k_run = 1'b1;
    logic k_clk, load_strobe_n, rw_select;
    logic [7:0] addr;
    logic [17:0] d_in, dq_out;
    logic [1:0] byte_write_select_n;
    logic dq_oe_n, read_data_valid_flag, odt_enable, dll_locked;
    logic echo_clock_true, echo_clock_comp;
    int err_total = 0;
    int num_checks = 0;

    // Core clock of 5 ns.
    always #2.5 ref_clk = ~ref_clk;

    // Both latency variants see the same traffic; the bound checker judges both, the checks here only the first.
    ddrsp_port #(.LOCK_CYCLES(LOCK_SIM)) u_dut (.ref_clk(ref_clk), .nrst(nrst),
        .k_clk(k_clk), .load_strobe_n(load_strobe_n), .rw_select(rw_select), .addr(addr),
        .d_in(d_in), .byte_write_select_n(byte_write_select_n), .dll_disable_n(dll_disable_n),
        .on_die_termination_control(on_die_termination_control), .dq_out(dq_out),
        .dq_oe_n(dq_oe_n), .echo_clock_true(echo_clock_true), .echo_clock_comp(echo_clock_comp),
        .read_data_valid_flag(read_data_valid_flag), .odt_enable(odt_enable),
        .dll_locked(dll_locked));
    ddrsp_port #(.RL_2P5(1'b0), .LOCK_CYCLES(LOCK_SIM)) u_dut_rl20 (.ref_clk(ref_clk),
        .nrst(nrst), .k_clk(k_clk), .load_strobe_n(load_strobe_n), .rw_select(rw_select),
        .addr(addr), .d_in(d_in), .byte_write_select_n(byte_write_select_n),
        .dll_disable_n(dll_disable_n), .on_die_termination_control(on_die_termination_control),
        .dq_out(), .dq_oe_n(), .echo_clock_true(), .echo_clock_comp(),
        .read_data_valid_flag(), .odt_enable(), .dll_locked());
    ddrsp_ctrl_model u_ctrl (.run(k_run), .k_clk(k_clk), .load_strobe_n(load_strobe_n),
        .rw_select(rw_select), .addr(addr), .d_in(d_in),
        .byte_write_select_n(byte_write_select_n));

    // Compares one value and counts it.
    task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Prints the counts and the verdict, then stops.
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    // Write burst: both beats of lane mask 0 except beat 1, which uses m1.
    task automatic wr(input logic [7:0] a, input logic [17:0] w0, input logic [17:0] w1,
                      input logic [1:0] m1);
        u_ctrl.cmd(1'b0, a, w0, 2'h0);
        u_ctrl.beat(w1, m1);
        repeat (2) @(posedge k_clk);
    endtask : wr

    // Read burst whose first word shows in half cycle h after the command rise.
    task automatic rd_check(input logic [7:0] a, input int h, input logic [17:0] w0,
                            input logic [17:0] w1);
        u_ctrl.cmd(1'b1, a, 18'h00000, 2'h3);
        repeat (h - 1) @(k_clk);
        #1;
        check("early drive", 18'(dq_oe_n), 18'h00001);
        @(k_clk);
        #1;
        check("word0", dq_out, w0);
        check("word0 drive", 18'(dq_oe_n), 18'h00000);
        check("word0 valid", 18'(read_data_valid_flag), 18'h00001);
        @(k_clk);
        #1;
        check("word1", dq_out, w1);
        @(k_clk);
        #1;
        check("float", 18'(dq_oe_n), 18'h00001);
        repeat (4) @(posedge k_clk);
    endtask : rd_check

    // Waits a bounded time for the delay loop to lock.
    task automatic wait_lock();
        int n;
        n = 0;
        while (dll_locked !== 1'b1 && n < 400) begin
            @(posedge ref_clk);
            n++;
        end
        check("lock", 18'(dll_locked), 18'h00001);
        if (dll_locked !== 1'b1) begin
            close_out();
        end
    endtask : wait_lock

    // Masked lanes keep data; burst order in bypass mode.
    task automatic test_bypass();
        wr(8'h04, 18'h0a5a5, 18'h1c3c3, 2'h0);
        wr(8'h04, 18'h12345, 18'h0f0f0, 2'h2);
        rd_check(8'h04, 2, 18'h12345, {9'h0e1, 9'h0f0});
        rd_check(8'h05, 2, {9'h0e1, 9'h0f0}, 18'h12345);
        $display("test_bypass done");
    endtask : test_bypass

    // Termination follows its control pin.
    task automatic test_odt();
        @(posedge ref_clk);
        on_die_termination_control <= 1'b1;
        repeat (6) @(posedge k_clk);
        #1;
        check("odt on", 18'(odt_enable), 18'h00001);
        @(posedge ref_clk);
        on_die_termination_control <= 1'b0;
        repeat (6) @(posedge k_clk);
        #1;
        check("odt off", 18'(odt_enable), 18'h00000);
        @(posedge k_clk);
        #1;
        check("echo rise", 18'({echo_clock_true, echo_clock_comp}), 18'h00002);
        @(negedge k_clk);
        #1;
        check("echo fall", 18'({echo_clock_true, echo_clock_comp}), 18'h00001);
        $display("test_odt done");
    endtask : test_odt

    // Normal mode with the loop locked: latency 2.5.
    task automatic test_lock();
        @(posedge ref_clk);
        dll_disable_n <= 1'b1;
        wait_lock();
        repeat (4) @(posedge k_clk);
        rd_check(8'h04, 5, 18'h12345, {9'h0e1, 9'h0f0});
        $display("test_lock done");
    endtask : test_lock

    // A still link clock drops lock; lock returns only after the full interval.
    task automatic test_static();
        @(posedge ref_clk);
        k_run <= 1'b0;
        repeat (20) @(posedge ref_clk);
        check("lock lost", 18'(dll_locked), 18'h00000);
        k_run <= 1'b1;
        repeat (20) @(posedge ref_clk);
        check("relock early", 18'(dll_locked), 18'h00000);
        wait_lock();
        repeat (4) @(posedge k_clk);
        rd_check(8'h05, 5, {9'h0e1, 9'h0f0}, 18'h12345);
        $display("test_static done");
    endtask : test_static

    // Bounds the whole run; running out counts as a mismatch.
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        close_out();
    end

    // Reset with the link clock running, then the scenarios.
    initial begin
        repeat (4) @(posedge ref_clk);
        repeat (4) @(posedge k_clk);
        @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (8) @(posedge k_clk);
        test_bypass();
        test_odt();
        test_lock();
        test_static();
        close_out();
    end
endmodule : testbench
